// [include/mcrs_pkg.sv]
// Shared constants and state codes for the maintenance card reset sequencer
package mcrs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock rate
   localparam longint unsigned CLOCK_HZ = 64'd40000000;

   ////////////////////////////////////////////////////////////////////////////
   // Timing figures in their own units and derived cycle counts
   localparam longint unsigned LONG_PRESS_MS = 64'd3500;
   localparam longint unsigned LONG_PRESS_CYC = (CLOCK_HZ * LONG_PRESS_MS + 64'd999) / 64'd1000;
   localparam longint unsigned MODEM_INIT_S = 64'd30;
   localparam longint unsigned MODEM_INIT_CYC = CLOCK_HZ * MODEM_INIT_S;

   // Width of the reset pulses driven out of the block
   localparam logic [7:0] PULSE_CYC = 8'h10;

   // Counter width for long timers
   localparam int TIMER_W = 32;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [TIMER_W-1:0] TIMER_RST = 32'h0;
   localparam logic [7:0] PULSE_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser bit positions
   localparam int PIN_POWER = 0;
   localparam int PIN_EXTBIOS = 1;
   localparam int PIN_HARDRST = 2;
   localparam int PIN_FARCTS = 3;
   localparam int PIN_COUNT = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Start-up sequence states, one-hot
   typedef enum logic [9:0] {
      MCRS_OFF      = 10'h001,
      MCRS_SELFTEST = 10'h002,
      MCRS_CHECK    = 10'h004,
      MCRS_DOWNLOAD = 10'h008,
      MCRS_BIOS     = 10'h010,
      MCRS_MODEM    = 10'h020,
      MCRS_CLEAR    = 10'h040,
      MCRS_CHOICE   = 10'h080,
      MCRS_RUN      = 10'h100,
      MCRS_SPARE    = 10'h200
   } mcrs_state_t;

endpackage

// [rtl/mcrs_button_timer.sv]
// Faceplate reset button synchroniser, press timer and press classifier
`timescale 1ns/1ps
module mcrs_button_timer
   import mcrs_pkg::*;
#(
   parameter logic [TIMER_W-1:0] LONG_CYCLES = TIMER_W'(LONG_PRESS_CYC)
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic resetButtonN,
   output logic shortPress,
   output logic longPress
);

   logic syncA_reg;
   logic syncB_reg;
   logic syncC_reg;
   logic pressed_reg;
   logic [TIMER_W-1:0] holdCount_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Three-stage synchroniser, button is active low
   always_ff @(posedge clock) begin
      if (rst) begin
         syncA_reg <= 1'b1;
         syncB_reg <= 1'b1;
         syncC_reg <= 1'b1;
      end else begin
         syncA_reg <= resetButtonN;
         syncB_reg <= syncA_reg;
         syncC_reg <= syncB_reg;
      end
   end

   // Press state follows only when the last two stages agree
   always_ff @(posedge clock) begin
      if (rst) begin
         pressed_reg <= 1'b0;
      end else if (syncB_reg == syncC_reg) begin
         pressed_reg <= ~syncC_reg;
      end
   end

   // Hold timer, saturating so very long presses stay long
   always_ff @(posedge clock) begin
      if (rst) begin
         holdCount_reg <= TIMER_RST;
      end else if (!pressed_reg) begin
         holdCount_reg <= TIMER_RST;
      end else if (holdCount_reg != {TIMER_W{1'b1}}) begin
         holdCount_reg <= holdCount_reg + 1'b1;
      end
   end

   // Classify on release only
   always_ff @(posedge clock) begin
      if (rst) begin
         shortPress <= 1'b0;
         longPress <= 1'b0;
      end else begin
         shortPress <= pressed_reg && (syncB_reg == syncC_reg) && syncC_reg
                       && (holdCount_reg <= LONG_CYCLES);
         longPress <= pressed_reg && (syncB_reg == syncC_reg) && syncC_reg
                      && (holdCount_reg > LONG_CYCLES);
      end
   end

endmodule

// [rtl/mcrs_sequencer.sv]
// Maintenance card reset causes, start-up sequence and platform reset handling
`timescale 1ns/1ps
module mcrs_sequencer
   import mcrs_pkg::*;
#(
   parameter logic [TIMER_W-1:0] LONG_PRESS_CYCLES = TIMER_W'(LONG_PRESS_CYC),
   parameter logic [TIMER_W-1:0] MODEM_INIT_CYCLES = TIMER_W'(MODEM_INIT_CYC),
   parameter bit HAS_INTERNAL_MODEM = 1'b1
) (
   input wire logic clock,
   input wire logic rst,
   // Pins
   input wire logic platformPower,
   input wire logic resetButtonN,
   input wire logic extendedBiosEnable,
   input wire logic platformResetSense,
   input wire logic farClearToSend,
   // Firmware and platform requests, same clock
   input wire logic cardResetCmd,
   input wire logic rebootCmd,
   input wire logic osShutdownReset,
   input wire logic postBegin,
   input wire logic independentReq,
   input wire logic selfTestDone,
   input wire logic imageCheckDone,
   input wire logic imageOk,
   input wire logic downloadDone,
   input wire logic biosLoadDone,
   input wire logic modemConfigDone,
   input wire logic modemReadyIn,
   input wire logic diagEnable,
   input wire logic keyContinue,
   input wire logic keyDiagnostics,
   input wire logic localRxReady,
   input wire logic comRxValid,
   input wire logic [7:0] comRxData,
   // Sequence outputs
   output logic cardResetOut,
   output logic modemResetOut,
   output logic dropCall,
   output logic selfTestRun,
   output logic postCaptureEn,
   output logic imageCheckRun,
   output logic downloadMode,
   output logic biosLoadRun,
   output logic modemConfigRun,
   output logic clearPostBuffer,
   output logic clearEventCounters,
   output logic rewritePostRecord,
   output logic loadDiagnostics,
   output logic choicePrompt,
   output logic normalState,
   output logic independentState,
   output logic modemOwnedByCard,
   output logic cmdAccept,
   output logic modemUsable,
   output logic modemInitFail,
   output logic platformResetOut,
   // Serial path
   output logic modemRtsOut,
   output logic comRxReady,
   output logic remoteTxValid,
   output logic [7:0] remoteTxData
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Saturating one-step countdown used by every pulse stretcher
   function automatic logic [7:0] countDown(input logic [7:0] cnt);
      countDown = (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [PIN_COUNT-1:0] pinA_reg;
   logic [PIN_COUNT-1:0] pinB_reg;
   logic [PIN_COUNT-1:0] pinC_reg;
   logic [PIN_COUNT-1:0] pinStable_reg;
   logic [PIN_COUNT-1:0] pinStable_next;
   logic powerPrev_reg;
   logic hardPrev_reg;
   logic powerRise;
   logic powerOn;
   logic hardRise;
   logic extBios;
   logic shortPress;
   logic longPress;
   logic fullReset;
   logic modemReset;
   mcrs_state_t state_reg;
   mcrs_state_t state_next;
   mcrs_state_t afterCheck;
   logic skipBios_reg;
   logic [7:0] cardPulse_reg;
   logic [7:0] modemPulse_reg;
   logic [7:0] platPulse_reg;
   logic [TIMER_W-1:0] modemTimer_reg;
   logic modemWait_reg;
   logic rewritePending_reg;
   logic runNext;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, change taken when last two agree
   always_ff @(posedge clock) begin
      if (rst) begin
         pinA_reg <= '0;
         pinB_reg <= '0;
         pinC_reg <= '0;
      end else begin
         pinA_reg <= {farClearToSend, platformResetSense, extendedBiosEnable, platformPower};
         pinB_reg <= pinA_reg;
         pinC_reg <= pinB_reg;
      end
   end

   // Bits where stages agree follow, others hold
   assign pinStable_next = (~(pinB_reg ^ pinC_reg) & pinC_reg)
                         | ((pinB_reg ^ pinC_reg) & pinStable_reg);

   always_ff @(posedge clock) begin
      if (rst) begin
         pinStable_reg <= '0;
         powerPrev_reg <= 1'b0;
         hardPrev_reg <= 1'b0;
      end else begin
         pinStable_reg <= pinStable_next;
         powerPrev_reg <= pinStable_reg[PIN_POWER];
         hardPrev_reg <= pinStable_reg[PIN_HARDRST];
      end
   end

   assign powerOn = pinStable_reg[PIN_POWER];
   assign powerRise = powerOn & ~powerPrev_reg;
   assign hardRise = pinStable_reg[PIN_HARDRST] & ~hardPrev_reg;
   assign extBios = pinStable_reg[PIN_EXTBIOS];

   ////////////////////////////////////////////////////////////////////////////
   // Faceplate button timing
   mcrs_button_timer #(
      .LONG_CYCLES(LONG_PRESS_CYCLES)
   ) buttonTimer (
      .clock(clock),
      .rst(rst),
      .resetButtonN(resetButtonN),
      .shortPress(shortPress),
      .longPress(longPress)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Reset causes
   // Full reset: power-on, long press, or accepted reset command only
   assign fullReset = powerRise | (longPress & powerOn)
                    | (cardResetCmd & cmdAccept);
   // Modem follows every full reset, and a short press on internal modem
   assign modemReset = fullReset
                     | (shortPress & HAS_INTERNAL_MODEM & powerOn);

   // Extended BIOS step is skipped after a reset command
   always_ff @(posedge clock) begin
      if (rst) begin
         skipBios_reg <= 1'b0;
      end else if (fullReset) begin
         skipBios_reg <= ~(powerRise | longPress);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start-up sequence
   // Step after image check or download
   assign afterCheck = (extBios && !skipBios_reg) ? MCRS_BIOS : MCRS_MODEM;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         MCRS_OFF: begin
            state_next = MCRS_OFF;
         end
         MCRS_SELFTEST: begin
            if (selfTestDone) begin
               state_next = MCRS_CHECK;
            end
         end
         MCRS_CHECK: begin
            if (imageCheckDone) begin
               state_next = imageOk ? afterCheck : MCRS_DOWNLOAD;
            end
         end
         MCRS_DOWNLOAD: begin
            if (downloadDone) begin
               state_next = afterCheck;
            end
         end
         MCRS_BIOS: begin
            if (biosLoadDone) begin
               state_next = MCRS_MODEM;
            end
         end
         MCRS_MODEM: begin
            if (modemConfigDone) begin
               state_next = MCRS_CLEAR;
            end
         end
         MCRS_CLEAR: begin
            state_next = diagEnable ? MCRS_CHOICE : MCRS_RUN;
         end
         MCRS_CHOICE: begin
            if (keyContinue || keyDiagnostics) begin
               state_next = MCRS_RUN;
            end
         end
         MCRS_RUN: begin
            state_next = MCRS_RUN;
         end
         default: begin
            state_next = MCRS_OFF;
         end
      endcase
      // Full reset causes restart the sequence; power loss stops it
      if (fullReset) begin
         state_next = MCRS_SELFTEST;
      end
      if (!powerOn) begin
         state_next = MCRS_OFF;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= MCRS_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   assign runNext = (state_next == MCRS_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // Step strobes and state flags
   always_ff @(posedge clock) begin
      if (rst) begin
         selfTestRun <= 1'b0;
         postCaptureEn <= 1'b0;
         imageCheckRun <= 1'b0;
         downloadMode <= 1'b0;
         biosLoadRun <= 1'b0;
         modemConfigRun <= 1'b0;
         choicePrompt <= 1'b0;
         cmdAccept <= 1'b0;
      end else begin
         selfTestRun <= (state_next == MCRS_SELFTEST);
         postCaptureEn <= (state_next != MCRS_OFF);
         imageCheckRun <= (state_next == MCRS_CHECK);
         downloadMode <= (state_next == MCRS_DOWNLOAD);
         biosLoadRun <= (state_next == MCRS_BIOS);
         modemConfigRun <= (state_next == MCRS_MODEM);
         choicePrompt <= (state_next == MCRS_CHOICE);
         cmdAccept <= runNext;
      end
   end

   // Modem ownership follows the operating state
   always_ff @(posedge clock) begin
      if (rst) begin
         normalState <= 1'b0;
         independentState <= 1'b0;
         modemOwnedByCard <= 1'b0;
      end else begin
         normalState <= runNext & ~independentReq;
         independentState <= runNext & independentReq;
         modemOwnedByCard <= runNext & independentReq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset pulse stretchers
   always_ff @(posedge clock) begin
      if (rst) begin
         cardPulse_reg <= PULSE_RST;
         modemPulse_reg <= PULSE_RST;
         platPulse_reg <= PULSE_RST;
      end else begin
         cardPulse_reg <= fullReset ? PULSE_CYC : countDown(cardPulse_reg);
         modemPulse_reg <= modemReset ? PULSE_CYC : countDown(modemPulse_reg);
         // Card-driven platform reset only from independent state
         platPulse_reg <= (rebootCmd && independentState && cmdAccept)
                        ? PULSE_CYC : countDown(platPulse_reg);
      end
   end

   // Platform resets never drop the call; only card or modem resets do
   always_ff @(posedge clock) begin
      if (rst) begin
         cardResetOut <= 1'b0;
         modemResetOut <= 1'b0;
         dropCall <= 1'b0;
         platformResetOut <= 1'b0;
      end else begin
         cardResetOut <= fullReset | (cardPulse_reg > 8'h01);
         modemResetOut <= modemReset | (modemPulse_reg > 8'h01);
         dropCall <= modemReset | (modemPulse_reg > 8'h01);
         platformResetOut <= (rebootCmd && independentState && cmdAccept)
                           | (platPulse_reg > 8'h01);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Modem initialisation window
   always_ff @(posedge clock) begin
      if (rst) begin
         modemTimer_reg <= TIMER_RST;
         modemWait_reg <= 1'b0;
         modemUsable <= 1'b0;
         modemInitFail <= 1'b0;
      end else if (modemReset || modemResetOut || !powerOn) begin
         modemTimer_reg <= TIMER_RST;
         modemWait_reg <= powerOn;
         modemUsable <= 1'b0;
         modemInitFail <= 1'b0;
      end else if (modemWait_reg) begin
         if (modemReadyIn) begin
            modemWait_reg <= 1'b0;
            modemUsable <= 1'b1;
         end else if (modemTimer_reg >= MODEM_INIT_CYCLES - 1'b1) begin
            modemWait_reg <= 1'b0;
            modemInitFail <= 1'b1;
         end else begin
            modemTimer_reg <= modemTimer_reg + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // POST record and event counter housekeeping
   // Pending rewrite after shutdown reset; a new set wins over the clear
   always_ff @(posedge clock) begin
      if (rst) begin
         rewritePending_reg <= 1'b0;
      end else begin
         rewritePending_reg <= osShutdownReset
                             | (rewritePending_reg & ~postBegin);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         clearPostBuffer <= 1'b0;
         clearEventCounters <= 1'b0;
         rewritePostRecord <= 1'b0;
         loadDiagnostics <= 1'b0;
      end else begin
         clearPostBuffer <= (state_reg == MCRS_CLEAR) && powerOn;
         clearEventCounters <= ((state_reg == MCRS_CLEAR) && powerOn)
                             | hardRise;
         rewritePostRecord <= (rewritePending_reg & postBegin)
                            | hardRise;
         loadDiagnostics <= ((state_reg == MCRS_CHOICE) && powerOn
                             && keyDiagnostics && !keyContinue)
                          | (hardRise & extBios);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial forwarding with hardware flow control
   // Far-end clear-to-send gates what the port accepts; not cut by reboots
   always_ff @(posedge clock) begin
      if (rst) begin
         modemRtsOut <= 1'b0;
         comRxReady <= 1'b0;
         remoteTxValid <= 1'b0;
         remoteTxData <= 8'h00;
      end else begin
         modemRtsOut <= localRxReady;
         comRxReady <= pinStable_reg[PIN_FARCTS];
         remoteTxValid <= comRxValid & comRxReady;
         if (comRxValid && comRxReady) begin
            remoteTxData <= comRxData;
         end
      end
   end

endmodule

// [test/mcrs_far_side.sv]
// Behavioural boot step agents and modem on the far side of the sequencer
`timescale 1ns/1ps
module mcrs_far_side #(
   parameter int STEP_DLY = 3,
   parameter int READY_DLY = 20
) (
   input wire logic clock,
   input wire logic imageGood,
   input wire logic modemMute,
   input wire logic selfTestRun,
   input wire logic imageCheckRun,
   input wire logic biosLoadRun,
   input wire logic modemConfigRun,
   input wire logic modemResetOut,
   output logic selfTestDone = 1'b0,
   output logic imageCheckDone = 1'b0,
   output logic imageOk = 1'b0,
   output logic biosLoadDone = 1'b0,
   output logic modemConfigDone = 1'b0,
   output logic modemReadyIn = 1'b0
);
   int stepCnt = 0;
   int modemCnt = 0;
   logic stepRun;
   logic stepEnd;
   assign stepRun = selfTestRun | imageCheckRun | biosLoadRun | modemConfigRun;
   assign stepEnd = stepCnt == STEP_DLY;
   ////////////////////////////////////////////////////////////////////////////
   // Each step agent answers a fixed time after its step starts
   always @(negedge clock) begin
      stepCnt <= (stepEnd || !stepRun) ? 0 : stepCnt + 1;
      selfTestDone <= selfTestRun && stepEnd;
      imageCheckDone <= imageCheckRun && stepEnd;
      imageOk <= imageCheckRun ? imageGood : !imageOk;
      biosLoadDone <= biosLoadRun && stepEnd;
      modemConfigDone <= modemConfigRun && stepEnd;
   end
   // Modem finishes its own start-up a while after its reset ends
   always @(negedge clock) begin
      modemCnt <= modemResetOut ? 0 : (modemCnt > READY_DLY ? modemCnt : modemCnt + 1);
      modemReadyIn <= !modemMute && modemCnt == READY_DLY;
   end
endmodule

// [test/mcrs_sequencer_props.sv]
// Port-level concurrent checks for the reset sequencer
`timescale 1ns/1ps
module mcrs_sequencer_props (
   input wire logic clock,
   input wire logic rst,
   input wire logic cardResetCmd,
   input wire logic rebootCmd,
   input wire logic comRxValid,
   input wire logic [7:0] comRxData,
   input wire logic cmdAccept,
   input wire logic cardResetOut,
   input wire logic modemResetOut,
   input wire logic dropCall,
   input wire logic selfTestRun,
   input wire logic independentState,
   input wire logic normalState,
   input wire logic modemOwnedByCard,
   input wire logic platformResetOut,
   input wire logic downloadMode,
   input wire logic rewritePostRecord,
   input wire logic comRxReady,
   input wire logic remoteTxValid,
   input wire logic [7:0] remoteTxData,
   input wire logic clearPostBuffer,
   input wire logic clearEventCounters,
   input wire logic choicePrompt
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   // Reset causes, ownership and gating
   cmd_reset_a: assert property (cardResetCmd && cmdAccept |=> cardResetOut && selfTestRun)
      else $error("Reset command did not restart the card");
   call_drop_a: assert property (dropCall == modemResetOut && (modemResetOut || !cardResetOut))
      else $error("Reset without the call being dropped");
   reboot_go_a: assert property (rebootCmd && independentState && cmdAccept |=> platformResetOut)
      else $error("Reboot in independent state gave no platform reset");
   reboot_gate_a: assert property (rebootCmd && !(independentState && cmdAccept)
      && !platformResetOut |=> !platformResetOut)
      else $error("Reboot honoured outside independent state");
   modem_owner_a: assert property (modemOwnedByCard == independentState
      && !(normalState && independentState))
      else $error("Modem owner does not follow the state");
   download_lock_a: assert property (downloadMode |-> !cmdAccept && !normalState)
      else $error("Commands open while downloading");
   post_keep_a: assert property (rewritePostRecord |-> !$rose(dropCall))
      else $error("Platform reset dropped the call");
   serial_fwd_a: assert property (comRxValid && comRxReady
      |=> remoteTxValid && remoteTxData == $past(comRxData))
      else $error("Serial byte not forwarded");
   clear_final_a: assert property (clearPostBuffer
      |-> clearEventCounters && (normalState || choicePrompt))
      else $error("Final clear step out of place");
   cover property (choicePrompt);
   cover property (downloadMode && cardResetCmd);
   cover property (rebootCmd && independentState);
endmodule

bind mcrs_sequencer mcrs_sequencer_props i_props (.clock, .rst, .cardResetCmd, .rebootCmd,
   .comRxValid, .comRxData, .cmdAccept, .cardResetOut, .modemResetOut, .dropCall,
   .selfTestRun, .independentState, .normalState, .modemOwnedByCard, .platformResetOut,
   .downloadMode, .rewritePostRecord, .comRxReady, .remoteTxValid, .remoteTxData,
   .clearPostBuffer, .clearEventCounters, .choicePrompt);

// [test/mcrs_sequencer_test.sv]
// Self-checking bench for the maintenance card reset sequencer
`timescale 1ns/1ps
module mcrs_sequencer_test;
   logic clock = 1'b0, rst = 1'b1, platformPower = 1'b0, resetButtonN = 1'b1;
   logic extendedBiosEnable = 1'b1, platformResetSense = 1'b0, farClearToSend = 1'b1;
   logic cardResetCmd = 1'b0, rebootCmd = 1'b0, osShutdownReset = 1'b0, postBegin = 1'b0;
   logic independentReq = 1'b0, downloadDone = 1'b0, diagEnable = 1'b0, keyContinue = 1'b0;
   logic keyDiagnostics = 1'b0, localRxReady = 1'b0, comRxValid = 1'b0;
   logic imageGood = 1'b1, modemMute = 1'b0;
   logic [7:0] comRxData = 8'h00, remoteTxData, lastTx = 8'h00;
   logic selfTestDone, imageCheckDone, imageOk, biosLoadDone, modemConfigDone, modemReadyIn;
   logic cardResetOut, modemResetOut, dropCall, selfTestRun, postCaptureEn, imageCheckRun;
   logic downloadMode, biosLoadRun, modemConfigRun, clearPostBuffer, clearEventCounters;
   logic rewritePostRecord, loadDiagnostics, choicePrompt, normalState, independentState;
   logic modemOwnedByCard, cmdAccept, modemUsable, modemInitFail, platformResetOut;
   logic modemRtsOut, comRxReady, remoteTxValid;
   logic [11:0] seen = 12'h000;
   int error_cnt = 0, total_checks = 0;

   always #12.5 clock = ~clock;

   mcrs_sequencer #(.LONG_PRESS_CYCLES(32'h32), .MODEM_INIT_CYCLES(32'h28)) i_dut (
      .clock, .rst, .platformPower, .resetButtonN, .extendedBiosEnable, .platformResetSense,
      .farClearToSend, .cardResetCmd, .rebootCmd, .osShutdownReset, .postBegin,
      .independentReq, .selfTestDone, .imageCheckDone, .imageOk, .downloadDone,
      .biosLoadDone, .modemConfigDone, .modemReadyIn, .diagEnable, .keyContinue,
      .keyDiagnostics, .localRxReady, .comRxValid, .comRxData, .cardResetOut, .modemResetOut,
      .dropCall, .selfTestRun, .postCaptureEn, .imageCheckRun, .downloadMode, .biosLoadRun,
      .modemConfigRun, .clearPostBuffer, .clearEventCounters, .rewritePostRecord,
      .loadDiagnostics, .choicePrompt, .normalState, .independentState, .modemOwnedByCard,
      .cmdAccept, .modemUsable, .modemInitFail, .platformResetOut, .modemRtsOut,
      .comRxReady, .remoteTxValid, .remoteTxData);

   mcrs_far_side i_far (.clock, .imageGood, .modemMute, .selfTestRun, .imageCheckRun,
      .biosLoadRun, .modemConfigRun, .modemResetOut, .selfTestDone, .imageCheckDone,
      .imageOk, .biosLoadDone, .modemConfigDone, .modemReadyIn);

   // Sticky record of pulses seen since a scenario cleared it
   always @(posedge clock) begin
      seen <= seen | {remoteTxValid, downloadMode, platformResetOut, clearEventCounters,
         rewritePostRecord, loadDiagnostics, dropCall, modemResetOut, cardResetOut,
         clearPostBuffer, biosLoadRun, selfTestRun};
      if (remoteTxValid) begin
         lastTx <= remoteTxData;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clock);
      s = 1'b0;
   endtask
   task automatic press(input int n);
      resetButtonN = 1'b0;
      idle(n);
      resetButtonN = 1'b1;
      idle(40);
   endtask
   task automatic wait_run();
      for (int n = 0; n < 400 && cmdAccept !== 1'b1; n++) @(negedge clock);
      idle(2);
   endtask
   task automatic results();
      $display("Checks made %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_power();
      // Drop unknowns picked up before the first reset edge
      seen = 12'h000;
      platformPower = 1'b1;
      wait_run();
      chk(seen, 12'h13f);
      chk({normalState, modemOwnedByCard, independentState}, 12'h004);
      chk(postCaptureEn, 1'b1);
      for (int n = 0; n < 100 && modemUsable !== 1'b1; n++) @(negedge clock);
      chk(modemUsable, 1'b1);
   endtask
   task automatic t_cmd_reset();
      diagEnable = 1'b1;
      seen = 12'h000;
      pulse(cardResetCmd);
      for (int n = 0; n < 400 && choicePrompt !== 1'b1; n++) @(negedge clock);
      idle(2);
      chk(seen, 12'h13d);
      chk(cmdAccept, 1'b0);
      pulse(keyDiagnostics);
      wait_run();
      chk(seen[6], 1'b1);
      diagEnable = 1'b0;
   endtask
   task automatic t_bad_image();
      imageGood = 1'b0;
      seen = 12'h000;
      press(80);
      pulse(cardResetCmd);
      idle(20);
      chk({downloadMode, cmdAccept, imageCheckRun, modemConfigRun}, 12'h008);
      imageGood = 1'b1;
      pulse(downloadDone);
      wait_run();
      chk(seen, 12'h53f);
   endtask
   task automatic t_short_press();
      modemMute = 1'b1;
      seen = 12'h000;
      press(20);
      chk(seen, 12'h030);
      chk(normalState, 1'b1);
      for (int n = 0; n < 100 && modemInitFail !== 1'b1; n++) @(negedge clock);
      chk({modemInitFail, modemUsable}, 12'h002);
      modemMute = 1'b0;
   endtask
   task automatic t_reboot();
      seen = 12'h000;
      pulse(rebootCmd);
      idle(20);
      chk(seen[9], 1'b0);
      independentReq = 1'b1;
      idle(4);
      chk({independentState, modemOwnedByCard, normalState}, 12'h006);
      pulse(rebootCmd);
      idle(20);
      chk(seen, 12'h200);
      independentReq = 1'b0;
      idle(4);
   endtask
   task automatic t_platform();
      seen = 12'h000;
      localRxReady = 1'b1;
      platformResetSense = 1'b1;
      idle(10);
      platformResetSense = 1'b0;
      chk(seen, 12'h1c0);
      // Same hard reset with the extended BIOS switch off: no diagnostics load
      extendedBiosEnable = 1'b0;
      idle(10);
      seen = 12'h000;
      platformResetSense = 1'b1;
      idle(10);
      platformResetSense = 1'b0;
      chk(seen, 12'h180);
      extendedBiosEnable = 1'b1;
      idle(10);
      seen = 12'h000;
      pulse(osShutdownReset);
      idle(3);
      pulse(postBegin);
      comRxData = 8'ha5;
      pulse(comRxValid);
      idle(3);
      chk(seen, 12'h880);
      chk(lastTx, 12'h0a5);
      chk(modemRtsOut, 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog
   initial begin
      idle(8);
      rst = 1'b0;
      idle(2);
      t_power();
      t_cmd_reset();
      t_bad_image();
      t_short_press();
      t_reboot();
      t_platform();
      results();
   end
   initial begin
      repeat (5000) @(posedge clock);
      error_cnt++;
      results();
   end
endmodule
